// ### core/asc_defines.vh
// timing constants and field widths for the static memory host controller
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// clock period in picoseconds (25 MHz)
`define ASC_CLK_PS        40000
// word address and data widths
`define ASC_ADDR_W        18
`define ASC_DATA_W        4
// documented times in picoseconds (fastest grade)
`define ASC_T_ACCESS_PS   10000
`define ASC_T_CW_PS       7000
`define ASC_T_AW_PS       7000
`define ASC_T_WP1_PS      10000
`define ASC_T_DW_PS       5000
`define ASC_T_HZ_PS       5000
`define ASC_T_OW_PS       3000
// least times round up to whole cycles, never below one
`define ASC_CYC_UP(t)     ((((t) + `ASC_CLK_PS - 1) / `ASC_CLK_PS) < 1 ? 1 : \
                           (((t) + `ASC_CLK_PS - 1) / `ASC_CLK_PS))
`define ASC_RD_CYC        `ASC_CYC_UP(`ASC_T_ACCESS_PS)
`define ASC_WP_CYC        `ASC_CYC_UP(`ASC_T_WP1_PS)
`define ASC_HZ_CYC        `ASC_CYC_UP(`ASC_T_HZ_PS)
`define ASC_OW_CYC        `ASC_CYC_UP(`ASC_T_OW_PS)
// counter width for the phase counter
`define ASC_CNT_W         4

`endif

// ### core/asc_host.v
// host controller driving an asynchronous 256k x 4 static memory
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.vh"

module asc_host #(
   parameter ADDR_W = `ASC_ADDR_W,
   parameter DATA_W = `ASC_DATA_W
) (
   // clock and reset
   input  wire              mclk,
   input  wire              rst_n,
   // user request side
   input  wire              req_valid,
   input  wire              req_write,
   input  wire [ADDR_W-1:0] req_addr,
   input  wire [DATA_W-1:0] req_wdata,
   output reg               req_ready,
   output reg               rsp_valid,
   output reg  [DATA_W-1:0] rsp_rdata,
   // memory pins
   output reg  [ADDR_W-1:0] word_address,
   output reg               sel_n,
   output reg               wstrobe_n,
   output reg               oe_n,
   input  wire [DATA_W-1:0] shared_data_lines_in,
   output reg  [DATA_W-1:0] shared_data_lines_out,
   output reg               shared_data_lines_oe
);

   // ----------------------------------------------------------------
   // states and timing
   // ----------------------------------------------------------------
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_RD    = 6'h02;
   localparam [5:0] ST_RDEND = 6'h04;
   localparam [5:0] ST_WR    = 6'h08;
   localparam [5:0] ST_WREND = 6'h10;
   localparam [5:0] ST_GAP   = 6'h20;

   // counts worked out as integers, then cut to the counter width on purpose
   localparam integer RD_CYC  = `ASC_RD_CYC;
   localparam integer WP_CYC  = `ASC_WP_CYC;
   localparam integer HZ_CYC  = `ASC_HZ_CYC;
   localparam integer OW_CYC  = `ASC_OW_CYC;
   // two extra cycles cover the synchroniser stages on read data
   localparam integer RD_WAIT = RD_CYC + 2;

   localparam [`ASC_CNT_W-1:0] RD_CNT = RD_WAIT[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] WP_CNT = WP_CYC[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] HZ_CNT = HZ_CYC[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] OW_CNT = OW_CYC[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] CNT_ONE = {{(`ASC_CNT_W-1){1'b0}}, 1'b1};

   reg [5:0]            state;
   reg [5:0]            next_state;
   reg [`ASC_CNT_W-1:0] cnt;
   reg [`ASC_CNT_W-1:0] next_cnt;
   reg                  next_req_ready;
   reg                  next_rsp_valid;
   reg [DATA_W-1:0]     next_rsp_rdata;
   reg [ADDR_W-1:0]     next_word_address;
   reg                  next_sel_n;
   reg                  next_wstrobe_n;
   reg                  next_oe_n;
   reg [DATA_W-1:0]     next_dout;
   reg                  next_dout_oe;
   wire                 cnt_last;
   wire                 take;
   // bus pins are asynchronous to mclk, so two flops before use
   reg [DATA_W-1:0]     din_meta;
   reg [DATA_W-1:0]     din_sync;

   // a request still showing ready is the one just taken, never a new one
   assign cnt_last = (cnt == CNT_ONE);
   assign take     = req_valid & ~req_ready;

   // ----------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         din_meta <= {DATA_W{1'b0}};
         din_sync <= {DATA_W{1'b0}};
      end else begin
         din_meta <= shared_data_lines_in;
         din_sync <= din_meta;
      end
   end

   // ----------------------------------------------------------------
   // access sequencer, next values
   // ----------------------------------------------------------------
   always @* begin
      next_state        = state;
      next_cnt          = cnt;
      next_req_ready    = 1'b0;
      next_rsp_valid    = 1'b0;
      next_rsp_rdata    = rsp_rdata;
      next_word_address = word_address;
      next_sel_n        = sel_n;
      next_wstrobe_n    = wstrobe_n;
      next_oe_n         = oe_n;
      next_dout         = shared_data_lines_out;
      next_dout_oe      = shared_data_lines_oe;
      case (state)
         ST_IDLE: begin
            // deselected: strobe and enable held high while idle
            next_sel_n     = 1'b1;
            next_wstrobe_n = 1'b1;
            next_oe_n      = 1'b1;
            if (take) begin
               next_req_ready    = 1'b1;
               next_word_address = req_addr;
               next_sel_n        = 1'b0;
               if (req_write) begin
                  // strobe and select fall together, data set up now
                  next_wstrobe_n = 1'b0;
                  next_dout      = req_wdata;
                  next_dout_oe   = 1'b1;
                  next_cnt       = WP_CNT;
                  next_state     = ST_WR;
               end else begin
                  // bus released before enable falls, strobe stays high
                  next_dout_oe   = 1'b0;
                  next_wstrobe_n = 1'b1;
                  next_oe_n      = 1'b0;
                  next_cnt       = RD_CNT;
                  next_state     = ST_RD;
               end
            end
         end
         ST_RD: begin
            // wait access time plus the two synchroniser stages
            if (cnt_last) begin
               next_rsp_rdata = din_sync;
               next_rsp_valid = 1'b1;
               next_sel_n     = 1'b1;
               next_oe_n      = 1'b1;
               next_cnt       = HZ_CNT;
               next_state     = ST_RDEND;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         ST_RDEND: begin
            // device needs up to 5 ns to release before we may drive
            if (cnt_last) begin
               next_state = ST_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         ST_WR: begin
            // pulse covers the 10 ns oe-low case too, one width for all
            if (cnt_last) begin
               next_wstrobe_n = 1'b1;
               next_sel_n     = 1'b1;
               next_state     = ST_WREND;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         ST_WREND: begin
            // data and address held one cycle past the write end
            next_dout_oe = 1'b0;
            next_cnt     = OW_CNT;
            next_state   = ST_GAP;
         end
         ST_GAP: begin
            if (cnt_last) begin
               next_state = ST_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // access sequencer, registers
   // ----------------------------------------------------------------
   // every pin comes straight from a flop so the memory sees no glitches
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state                 <= ST_IDLE;
         cnt                   <= {`ASC_CNT_W{1'b0}};
         req_ready             <= 1'b0;
         rsp_valid             <= 1'b0;
         rsp_rdata             <= {DATA_W{1'b0}};
         word_address          <= {ADDR_W{1'b0}};
         sel_n                 <= 1'b1;
         wstrobe_n             <= 1'b1;
         oe_n                  <= 1'b1;
         shared_data_lines_out <= {DATA_W{1'b0}};
         shared_data_lines_oe  <= 1'b0;
      end else begin
         state                 <= next_state;
         cnt                   <= next_cnt;
         req_ready             <= next_req_ready;
         rsp_valid             <= next_rsp_valid;
         rsp_rdata             <= next_rsp_rdata;
         word_address          <= next_word_address;
         sel_n                 <= next_sel_n;
         wstrobe_n             <= next_wstrobe_n;
         oe_n                  <= next_oe_n;
         shared_data_lines_out <= next_dout;
         shared_data_lines_oe  <= next_dout_oe;
      end
   end

endmodule // asc_host
`default_nettype wire

// ### dv/asc_sram_model.sv
// behavioural static memory facing the host controller
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
   // pins
   input  wire logic        mclk,
   input  wire logic [17:0] word_address,
   input  wire logic        sel_n, wstrobe_n, oe_n, host_oe,
   input  wire logic [3:0]  host_d,
   output var  logic [3:0]  bus
);
   logic [3:0] mem [int];
   logic [3:0] last = 4'h5;
   // undriven bus flips each cycle so a stale value never passes
   always @(posedge mclk) last <= bus;
   always @* begin
      if (!sel_n && wstrobe_n && !oe_n)
         bus = mem.exists(word_address) ? mem[word_address] : 4'h0;
      else if (host_oe) bus = host_d;
      else bus = ~last;
   end
   always @* if (!sel_n && !wstrobe_n) mem[word_address] = bus;
endmodule // asc_sram_model
`default_nettype wire

// ### dv/asc_host_properties.sv
// pin timing checks for the host controller
`timescale 1ns/1ps
`default_nettype none
module asc_host_properties (
   input wire logic        mclk, rst_n, req_ready, rsp_valid,
   input wire logic [17:0] word_address,
   input wire logic        sel_n, wstrobe_n, oe_n, shared_data_lines_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_no_drive_read: assert property (shared_data_lines_oe |-> oe_n) else $error("host drives in read");
   a_strobe_with_sel: assert property (!wstrobe_n |-> !sel_n) else $error("strobe without select");
   a_read_strobe_high: assert property (!oe_n |-> wstrobe_n) else $error("strobe low in read");
   a_write_addr_held: assert property (!wstrobe_n |=> $stable(word_address)) else $error("address moved");
   a_data_setup: assert property (!wstrobe_n |-> shared_data_lines_oe) else $error("no data in write");
   a_data_hold: assert property ($rose(wstrobe_n) |-> shared_data_lines_oe ##1 !shared_data_lines_oe)
      else $error("data hold wrong");
   a_read_window: assert property ($fell(oe_n) |-> !oe_n [*3] ##1 oe_n) else $error("read window");
   a_read_answer: assert property (req_ready && !oe_n |-> ##3 rsp_valid) else $error("late read data");
   a_ready_pulse: assert property (req_ready |=> !req_ready) else $error("ready not a pulse");
endmodule // asc_host_properties
bind asc_host asc_host_properties CHK (.mclk, .rst_n, .req_ready, .rsp_valid, .word_address, .sel_n,
   .wstrobe_n, .oe_n, .shared_data_lines_oe);
`default_nettype wire

// ### dv/asc_host_tb_top.sv
// self-checking bench for the host controller
`timescale 1ns/1ps
`default_nettype none
module asc_host_tb_top;
   logic mclk = 0, rst_n = 0, req_valid = 0, req_write = 0;
   logic [17:0] req_addr = 0, a;
   logic [3:0]  req_wdata = 0, d, bus, ref_m [int];
   wire logic   req_ready, rsp_valid, sel_n, wstrobe_n, oe_n, host_oe;
   wire logic [3:0]  rsp_rdata, host_d;
   wire logic [17:0] word_address;
   integer n_errors = 0, checks = 0, seed = 99806, i, j;
   logic [17:0] aq [$];
   initial forever #20 mclk = ~mclk;
   asc_host DUT (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .word_address(word_address), .sel_n(sel_n), .wstrobe_n(wstrobe_n),
      .oe_n(oe_n), .shared_data_lines_in(bus), .shared_data_lines_out(host_d),
      .shared_data_lines_oe(host_oe));
   asc_sram_model MEM (.mclk(mclk), .word_address(word_address), .sel_n(sel_n), .wstrobe_n(wstrobe_n),
      .oe_n(oe_n), .host_oe(host_oe), .host_d(host_d), .bus(bus));
   task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wrap_up;
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // wait a bounded number of cycles for a flag, a hang counts as a mismatch
   task wait_for(input integer which);
      integer k;
      k = 0;
      do begin
         @(posedge mclk);
         #1 k++;
      end while (!(which ? rsp_valid === 1'b1 : req_ready === 1'b1) && k < 20);
      if (k >= 20) begin
         n_errors++;
         wrap_up;
      end
   endtask
   task op(input logic w, input logic [17:0] ad, input logic [3:0] dd);
      // one edge between requests so req_valid never changes twice at once
      @(posedge mclk);
      #1 req_valid = 1;
      req_write = w;
      req_addr = ad;
      req_wdata = dd;
      wait_for(0);
      req_valid = 0;
      if (!w) begin
         wait_for(1);
         check("read data", rsp_rdata, ref_m.exists(ad) ? ref_m[ad] : 4'h0);
      end
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      #1 rst_n = 1;
      for (i = 0; i < 24; i++) begin
         a = (i < 2) ? {18{i[0]}} : 18'($random(seed));
         d = 4'($random(seed));
         op(1, a, d);
         ref_m[a] = d;
         aq.push_back(a);
         if (i % 3 == 0) op(0, a, 4'h0);
      end
      for (j = 0; j < 24; j++) op(0, aq[j], 4'h0);
      wrap_up;
   end
endmodule // asc_host_tb_top
`default_nettype wire
